// ---- shared/pmd_map.svh ----
// Timing constants for the page-mode memory controller, as `define macros.
// Assumes a 4 ns system clock; every cycle count but PMD_INIT_CBR and PMD_PAGE_GUARD is derived from a printed time.
// Notes on behaviour
// - After power-up hold both strobes high 200 us, then eight init cycles.
// - Init uses eight column-before-row refreshes, since refresh uses the counter.
// - Row strobe falls no closer together than 140 ns.
// - Write enable stays high after the strobes rise in a read.
// - Output enable high at least 25 ns before the controller drives data.
// - Output enable low at least 10 ns before the row strobe rises.
// - Page-mode column strobe cycles repeat no faster than 53 ns.
// - Column strobe stays high at least 10 ns between page accesses.
// - Refresh column strobe falls before row strobe, held low 15 ns after.
// - Column strobe high at least 10 ns before a refresh.
// - All 512 rows are refreshed within every 64 ms.
`ifndef PMD_MAP_SVH
`define PMD_MAP_SVH
`define PMD_CLK_NS 4
`define PMD_CYC_MIN(t) (((t) <= `PMD_CLK_NS) ? 1 : \
  (((t) + `PMD_CLK_NS - 1) / `PMD_CLK_NS))
`define PMD_CYC_MAX(t) (((t) < `PMD_CLK_NS) ? 1 : ((t) / `PMD_CLK_NS))
`define PMD_T_INIT_US 200
`define PMD_INIT_CYC (`PMD_T_INIT_US * 1000 / `PMD_CLK_NS)
`define PMD_INIT_CBR 8
`define PMD_T_REF_MS 64
`define PMD_ROWS 512
`define PMD_REF_CYC (`PMD_T_REF_MS * 1000000 / `PMD_ROWS / `PMD_CLK_NS)
`define PMD_T_RC_NS 140
`define PMD_T_RP_NS 60
`define PMD_T_RAS_MIN_NS 70
`define PMD_T_RAS_MAX_NS 100000
`define PMD_T_RAH_NS 10
`define PMD_T_RCD_NS 20
`define PMD_T_CAS_NS 25
`define PMD_T_CAC_NS 25
`define PMD_T_AA_NS 43
`define PMD_T_RAC_NS 70
`define PMD_T_CPA_NS 53
`define PMD_T_PC_NS 53
`define PMD_T_CP_NS 10
`define PMD_T_CHR_NS 15
`define PMD_T_WCH_NS 15
`define PMD_T_OEA_NS 22
`define PMD_T_OED_NS 25
`define PMD_RC_CYC `PMD_CYC_MIN(`PMD_T_RC_NS)
`define PMD_RP_CYC `PMD_CYC_MIN(`PMD_T_RP_NS)
`define PMD_RAS_MIN_CYC `PMD_CYC_MIN(`PMD_T_RAS_MIN_NS)
`define PMD_RAS_MAX_CYC `PMD_CYC_MAX(`PMD_T_RAS_MAX_NS)
`define PMD_RAH_CYC `PMD_CYC_MIN(`PMD_T_RAH_NS)
`define PMD_RCD_CYC `PMD_CYC_MIN(`PMD_T_RCD_NS)
`define PMD_CAS_CYC `PMD_CYC_MIN(`PMD_T_CAS_NS)
`define PMD_CAC_CYC `PMD_CYC_MIN(`PMD_T_CAC_NS)
`define PMD_AA_CYC `PMD_CYC_MIN(`PMD_T_AA_NS)
`define PMD_RAC_CYC `PMD_CYC_MIN(`PMD_T_RAC_NS)
`define PMD_CPA_CYC `PMD_CYC_MIN(`PMD_T_CPA_NS)
`define PMD_PC_CYC `PMD_CYC_MIN(`PMD_T_PC_NS)
`define PMD_CP_CYC `PMD_CYC_MIN(`PMD_T_CP_NS)
`define PMD_CHR_CYC `PMD_CYC_MIN(`PMD_T_CHR_NS)
`define PMD_WCH_CYC `PMD_CYC_MIN(`PMD_T_WCH_NS)
`define PMD_OEA_CYC `PMD_CYC_MIN(`PMD_T_OEA_NS)
`define PMD_OED_CYC `PMD_CYC_MIN(`PMD_T_OED_NS)
`define PMD_PAGE_GUARD 64
`endif

// ---- shared/pmd_pkg.sv ----
// Types shared by the page-mode memory controller files.
// Assumes the timing header is compiled alongside.
package pmd_pkg;
  typedef logic [8:0] pmd_maddr_t;
  typedef logic [17:0] pmd_addr_t;
  typedef enum logic [3:0] {
    PMD_PAUSE = 4'h0,
    PMD_IDLE = 4'h1,
    PMD_TAKE = 4'h2,
    PMD_ROW = 4'h3,
    PMD_CAS = 4'h4,
    PMD_CP = 4'h5,
    PMD_PGW = 4'h6,
    PMD_CBRC = 4'h7,
    PMD_CBRR = 4'h8,
    PMD_RP = 4'h9
  } pmd_state_e;
endpackage

// ---- design/pmd_buf.sv ----
// Two-entry read data buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module pmd_buf #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic head_v_reg, head_v_next, tail_v_reg, tail_v_next;
  logic [WIDTH-1:0] head_reg, head_next, tail_reg, tail_next;
  logic push, pop;

  // The head word drives the output; the tail catches a word during a stall.
  assign in_ready = !tail_v_reg;
  assign out_valid = head_v_reg;
  assign out_data = head_reg;
  assign push = in_valid && !tail_v_reg;
  assign pop = head_v_reg && out_ready;

  // Next contents of the two slots.
  always_comb begin
    head_v_next = head_v_reg;
    head_next = head_reg;
    tail_v_next = tail_v_reg;
    tail_next = tail_reg;
    if (pop) begin
      if (tail_v_reg) begin
        head_next = tail_reg;
        tail_v_next = 1'b0;
      end else begin
        head_v_next = push;
        head_next = in_data;
      end
    end else if (push && !head_v_reg) begin
      head_v_next = 1'b1;
      head_next = in_data;
    end else if (push) begin
      tail_v_next = 1'b1;
      tail_next = in_data;
    end
  end

  // Slot registers.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
      head_reg <= '0;
      tail_reg <= '0;
    end else begin
      head_v_reg <= head_v_next;
      tail_v_reg <= tail_v_next;
      head_reg <= head_next;
      tail_reg <= tail_next;
    end
  end
endmodule

// ---- design/pmd_ctrl.sv ----
// Host controller for a 256K x 4 fast-page-mode dynamic memory.
// Assumes the memory pins are sampled and driven on sys_clk at 250 MHz.
`timescale 1ns/100ps
`include "pmd_map.svh"
module pmd_ctrl #(
  parameter int INIT_CYC = `PMD_INIT_CYC,
  parameter int REF_CYC = `PMD_REF_CYC,
  parameter int RAS_MAX_CYC = `PMD_RAS_MAX_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire pmd_pkg::pmd_addr_t req_addr,
  input wire logic [3:0] req_wdata,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [3:0] rd_data,
  output logic init_done,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic oe_n,
  output pmd_pkg::pmd_maddr_t mux_address,
  input wire logic [3:0] data_line_i,
  output logic [3:0] data_line_o,
  output logic data_line_oe
);
  import pmd_pkg::*;

  pmd_state_e state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next, ras_cnt_reg, ras_cnt_next;
  logic [15:0] ref_cnt_reg, ref_cnt_next;
  logic [7:0] col_cnt_reg, col_cnt_next, pc_cnt_reg, pc_cnt_next;
  logic [7:0] rel_cnt_reg, rel_cnt_next;
  logic [3:0] init_cnt_reg, init_cnt_next;
  logic ref_pend_reg, ref_pend_next, ref_set, ref_clr;
  logic init_done_reg, init_done_next, ready_reg, ready_next;
  logic page_reg, page_next, wr_reg, wr_next;
  logic ras_n_reg, ras_n_next, cas_n_reg, cas_n_next;
  logic we_n_reg, we_n_next, oe_n_reg, oe_n_next;
  logic dq_oe_reg, dq_oe_next;
  logic [3:0] dq_o_reg, dq_o_next, wdata_reg, wdata_next;
  pmd_addr_t addr_reg, addr_next;
  pmd_maddr_t maddr_reg, maddr_next;
  logic buf_push, buf_room, rel_ok, can_page, rd_done;

  // Read words wait here so a stalled reader loses nothing.
  pmd_buf #(.WIDTH(4)) u_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(buf_push),
    .in_ready(buf_room),
    .in_data(data_line_i),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // Pin and handshake outputs come straight from their registers.
  assign req_ready = ready_reg;
  assign init_done = init_done_reg;
  assign ras_n = ras_n_reg;
  assign cas_n = cas_n_reg;
  assign we_n = we_n_reg;
  assign oe_n = oe_n_reg;
  assign mux_address = maddr_reg;
  assign data_line_o = dq_o_reg;
  assign data_line_oe = dq_oe_reg;

  // Bus is free for our drive once the memory has let go after a read.
  assign rel_ok = rel_cnt_reg > 8'(`PMD_OED_CYC);
  // A read needs the slowest of row, column, address and enable access.
  assign rd_done = cnt_reg > 16'(`PMD_CAC_CYC)
    && cnt_reg > 16'(`PMD_OEA_CYC)
    && ras_cnt_reg > 16'(`PMD_RAC_CYC)
    && col_cnt_reg > (page_reg ? 8'(`PMD_CPA_CYC) : 8'(`PMD_AA_CYC));
  // A waiting request to the open row may reuse it in page mode.
  assign can_page = req_valid && req_addr[17:9] == addr_reg[17:9]
    && !ref_pend_reg
    && ras_cnt_reg < 16'(RAS_MAX_CYC - `PMD_PAGE_GUARD)
    && (req_write ? rel_ok : buf_room);

  // Free-running timers and the refresh request flag.
  always_comb begin
    ref_set = 1'b0;
    ref_cnt_next = ref_cnt_reg + 16'h0001;
    if (ref_cnt_reg >= 16'(REF_CYC - 1)) begin
      ref_cnt_next = 16'h0000;
      ref_set = init_done_reg;
    end
    // A new request wins over a clear in the same cycle.
    ref_pend_next = ref_set || (ref_pend_reg && !ref_clr);
  end

  // Sequencer: strobes, address mux, data drive and access timing.
  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg == 16'hFFFF) ? cnt_reg : cnt_reg + 16'h0001;
    ras_cnt_next = (ras_cnt_reg == 16'hFFFF) ? ras_cnt_reg
      : ras_cnt_reg + 16'h0001;
    col_cnt_next = (col_cnt_reg == 8'hFF) ? col_cnt_reg
      : col_cnt_reg + 8'h01;
    pc_cnt_next = (pc_cnt_reg == 8'hFF) ? pc_cnt_reg : pc_cnt_reg + 8'h01;
    rel_cnt_next = (rel_cnt_reg == 8'hFF) ? rel_cnt_reg
      : rel_cnt_reg + 8'h01;
    init_cnt_next = init_cnt_reg;
    init_done_next = init_done_reg;
    ready_next = 1'b0;
    page_next = page_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    ras_n_next = ras_n_reg;
    cas_n_next = cas_n_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    dq_oe_next = dq_oe_reg;
    dq_o_next = dq_o_reg;
    maddr_next = maddr_reg;
    ref_clr = 1'b0;
    buf_push = 1'b0;
    case (state_reg)
      PMD_PAUSE: begin
        if (cnt_reg >= 16'(INIT_CYC)) begin
          cnt_next = 16'h0000;
          state_next = PMD_IDLE;
        end
      end
      PMD_IDLE: begin
        if ((!init_done_reg || ref_pend_reg)
            && ras_cnt_reg > 16'(`PMD_RC_CYC)) begin
          cas_n_next = 1'b0;
          state_next = PMD_CBRC;
        end else if (req_valid && init_done_reg
            && ras_cnt_reg > 16'(`PMD_RC_CYC)
            && (req_write ? rel_ok : buf_room)) begin
          maddr_next = req_addr[17:9];
          ready_next = 1'b1;
          page_next = 1'b0;
          state_next = PMD_TAKE;
        end
      end
      PMD_TAKE: begin
        wr_next = req_write;
        addr_next = req_addr;
        wdata_next = req_wdata;
        if (req_write) begin
          we_n_next = 1'b0;
          dq_o_next = req_wdata;
          dq_oe_next = 1'b1;
        end
        cnt_next = 16'h0000;
        if (page_reg) begin
          state_next = PMD_PGW;
        end else begin
          ras_n_next = 1'b0;
          ras_cnt_next = 16'h0000;
          state_next = PMD_ROW;
        end
      end
      PMD_ROW: begin
        if (cnt_reg == 16'(`PMD_RAH_CYC)) begin
          maddr_next = addr_reg[8:0];
          col_cnt_next = 8'h00;
        end
        if (cnt_reg > 16'(`PMD_RAH_CYC)
            && cnt_reg >= 16'(`PMD_RCD_CYC)) begin
          cas_n_next = 1'b0;
          oe_n_next = wr_reg;
          pc_cnt_next = 8'h00;
          cnt_next = 16'h0000;
          state_next = PMD_CAS;
        end
      end
      PMD_CAS: begin
        if (!wr_reg && rd_done) begin
          buf_push = 1'b1;
          cas_n_next = 1'b1;
          oe_n_next = 1'b1;
          rel_cnt_next = 8'h00;
          cnt_next = 16'h0000;
          state_next = PMD_CP;
        end else if (wr_reg && cnt_reg > 16'(`PMD_CAS_CYC)
            && cnt_reg > 16'(`PMD_WCH_CYC)) begin
          cas_n_next = 1'b1;
          we_n_next = 1'b1;
          dq_oe_next = 1'b0;
          cnt_next = 16'h0000;
          state_next = PMD_CP;
        end
      end
      PMD_CP: begin
        // Write enable is never lowered here after a read.
        if (can_page) begin
          maddr_next = req_addr[8:0];
          col_cnt_next = 8'h00;
          page_next = 1'b1;
          ready_next = 1'b1;
          state_next = PMD_TAKE;
        end else if (ras_cnt_reg > 16'(`PMD_RAS_MIN_CYC)) begin
          ras_n_next = 1'b1;
          cnt_next = 16'h0000;
          state_next = PMD_RP;
        end
      end
      PMD_PGW: begin
        if (col_cnt_reg >= 8'(`PMD_CP_CYC)
            && pc_cnt_reg > 8'(`PMD_PC_CYC)) begin
          cas_n_next = 1'b0;
          oe_n_next = wr_reg;
          pc_cnt_next = 8'h00;
          cnt_next = 16'h0000;
          state_next = PMD_CAS;
        end
      end
      PMD_CBRC: begin
        ras_n_next = 1'b0;
        ras_cnt_next = 16'h0000;
        cnt_next = 16'h0000;
        state_next = PMD_CBRR;
      end
      PMD_CBRR: begin
        if (cnt_reg > 16'(`PMD_CHR_CYC)) begin
          cas_n_next = 1'b1;
        end
        if (cas_n_reg && ras_cnt_reg > 16'(`PMD_RAS_MIN_CYC)) begin
          ras_n_next = 1'b1;
          ref_clr = 1'b1;
          cnt_next = 16'h0000;
          if (!init_done_reg) begin
            init_cnt_next = init_cnt_reg + 4'h1;
          end
          state_next = PMD_RP;
        end
      end
      PMD_RP: begin
        if (cnt_reg >= 16'(`PMD_RP_CYC)) begin
          if (init_cnt_reg >= 4'(`PMD_INIT_CBR)) begin
            init_done_next = 1'b1;
          end
          state_next = PMD_IDLE;
        end
      end
      default: begin
        state_next = PMD_PAUSE;
      end
    endcase
  end

  // State registers; strobes and drive are off from reset.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= PMD_PAUSE;
      cnt_reg <= 16'h0000;
      ras_cnt_reg <= 16'hFFFF;
      ref_cnt_reg <= 16'h0000;
      col_cnt_reg <= 8'h00;
      pc_cnt_reg <= 8'hFF;
      rel_cnt_reg <= 8'hFF;
      init_cnt_reg <= 4'h0;
      ref_pend_reg <= 1'b0;
      init_done_reg <= 1'b0;
      ready_reg <= 1'b0;
      page_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= 4'h0;
      ras_n_reg <= 1'b1;
      cas_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      dq_oe_reg <= 1'b0;
      dq_o_reg <= 4'h0;
      maddr_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ras_cnt_reg <= ras_cnt_next;
      ref_cnt_reg <= ref_cnt_next;
      col_cnt_reg <= col_cnt_next;
      pc_cnt_reg <= pc_cnt_next;
      rel_cnt_reg <= rel_cnt_next;
      init_cnt_reg <= init_cnt_next;
      ref_pend_reg <= ref_pend_next;
      init_done_reg <= init_done_next;
      ready_reg <= ready_next;
      page_reg <= page_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      ras_n_reg <= ras_n_next;
      cas_n_reg <= cas_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      dq_oe_reg <= dq_oe_next;
      dq_o_reg <= dq_o_next;
      maddr_reg <= maddr_next;
    end
  end
endmodule

// ---- tb/pmd_checker.sv ----
// Pin timing checker for the page-mode memory controller.
// Assumes it is bound to pmd_ctrl and sees one clock domain.
`timescale 1ns/100ps
module pmd_checker #(
  parameter int INIT_CYC = 20,
  parameter int REF_CYC = 300,
  parameter int RAS_MAX_CYC = 100
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic init_done,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic data_line_oe
);
  int up_reg, ini_reg, rgap_reg, ref_reg;
  int rlo_reg, chi_reg, ohi_reg, cgap_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Counts time since reset, row strobe falls and refreshes.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      up_reg <= 0;
      ini_reg <= 0;
      rgap_reg <= 1000;
      ref_reg <= 0;
    end else begin
      up_reg <= up_reg + 1;
      ini_reg <= ini_reg + ($fell(ras_n) ? 1 : 0);
      rgap_reg <= $fell(ras_n) ? 1 : rgap_reg + 1;
      ref_reg <= ($fell(ras_n) && !cas_n) ? 0 : ref_reg + 1;
    end
  end
  // Counts how long the row strobe has held low, the column strobe and output enable high, and cycles since the column strobe fell.
  // Reset keeps an unknown strobe level at power-up out of the counts.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rlo_reg <= 0;
      chi_reg <= 0;
      ohi_reg <= 0;
      cgap_reg <= 0;
    end else begin
      rlo_reg <= ras_n ? 0 : rlo_reg + 1;
      chi_reg <= cas_n ? chi_reg + 1 : 0;
      ohi_reg <= oe_n ? ohi_reg + 1 : 0;
      cgap_reg <= $fell(cas_n) ? 1 : cgap_reg + 1;
    end
  end
  a_init_pause_high: assert property (
    up_reg < INIT_CYC - 1 |-> ras_n && cas_n)
    else $error("strobe active in power-up pause");
  a_init_eight_cbr: assert property (
    $rose(init_done) |-> ini_reg >= 8)
    else $error("ready before eight init cycles");
  a_init_no_rasonly: assert property (
    !init_done && $fell(ras_n) |-> !cas_n)
    else $error("init cycle without column strobe lead");
  a_row_cycle_min: assert property (
    $fell(ras_n) |-> rgap_reg >= 35)
    else $error("row cycle too short");
  a_read_we_hold: assert property (
    !ras_n && !cas_n && we_n ##1 cas_n |-> we_n)
    else $error("write enable dropped at end of read");
  a_oe_before_drive: assert property (
    $rose(data_line_oe) |-> oe_n && ohi_reg >= 7)
    else $error("data driven too soon after output enable");
  a_oe_ras_lead: assert property (
    $fell(oe_n) |-> !ras_n [*3])
    else $error("output enable lead to row strobe too short");
  a_page_cycle_min: assert property (
    $fell(cas_n) && !ras_n |-> cgap_reg >= 14 && chi_reg >= 3)
    else $error("column cycle or precharge too short");
  a_cbr_hold_low: assert property (
    $fell(ras_n) && !cas_n |-> !cas_n [*4])
    else $error("refresh column hold too short");
  a_cbr_precharge: assert property (
    $fell(cas_n) && ras_n |-> chi_reg >= 3)
    else $error("refresh column precharge too short");
  a_ras_width: assert property (
    $rose(ras_n) |-> rlo_reg >= 18 && rlo_reg <= RAS_MAX_CYC)
    else $error("row strobe pulse out of range");
  a_refresh_due: assert property (
    init_done |-> ref_reg <= REF_CYC + RAS_MAX_CYC + 100)
    else $error("refresh overdue");
  c_refresh: cover property ($fell(ras_n) && !cas_n && init_done);
  c_page: cover property ($fell(cas_n) && !ras_n && cgap_reg < 30);
  c_write: cover property ($rose(data_line_oe));
endmodule

bind pmd_ctrl pmd_checker #(
  .INIT_CYC(INIT_CYC),
  .REF_CYC(REF_CYC),
  .RAS_MAX_CYC(RAS_MAX_CYC)
) u_chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .init_done(init_done),
  .ras_n(ras_n),
  .cas_n(cas_n),
  .we_n(we_n),
  .oe_n(oe_n),
  .data_line_oe(data_line_oe)
);

// ---- tb/pmd_mem.sv ----
// Behavioural model of the 256K x 4 page-mode memory at its pins.
// Assumes the controller drives all strobes; times are in ns.
`timescale 1ns/100ps
module pmd_mem (
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic slow,
  input wire pmd_pkg::pmd_maddr_t mux_address,
  input wire logic [3:0] data_line_o,
  output logic [3:0] data_line,
  output logic drv
);
  import pmd_pkg::*;
  logic [3:0] mem [int];
  pmd_maddr_t row;
  logic [8:0] ref_ctr = 9'h000;
  logic [3:0] word;
  logic early;
  realtime t_ras = 0.0, t_cas = 0.0, t_col = 0.0, t_oe = 0.0;
  realtime t_cp = 0.0, t_ok = 0.0;
  function automatic realtime mx(input realtime a, input realtime b);
    return (a > b) ? a : b;
  endfunction
  // Latches the row, or refreshes when the column strobe leads.
  always @(negedge ras_n) begin
    t_ras = $realtime;
    if (!cas_n) ref_ctr = ref_ctr + 9'h001;
    else row = mux_address;
  end
  // Early write stores the word; otherwise the read word is fetched.
  always @(negedge cas_n) begin
    t_cas = $realtime;
    early = !we_n;
    if (!ras_n && early) mem[int'({row, mux_address})] = data_line_o;
    word = mem.exists(int'({row, mux_address})) ?
      mem[int'({row, mux_address})] : 4'h0;
  end
  // Edge times that bound the access.
  always @(mux_address) t_col = $realtime;
  always @(negedge oe_n) t_oe = $realtime;
  always @(posedge cas_n) t_cp = $realtime;
  // Drives data once access has elapsed; a toggling pattern otherwise.
  initial begin
    data_line = 4'h5;
    drv = 1'b0;
    #0.5;
    forever begin
      t_ok = slow ? mx(mx(mx(t_ras + 70, t_cas + 25),
        mx(t_col + 43, t_oe + 22)), t_cp + 53) : t_cas + 5;
      drv = !cas_n && !oe_n && !early && $realtime >= t_ok;
      data_line = drv ? word : ~data_line;
      #1;
    end
  end
endmodule

// ---- tb/test_pmd_ctrl.sv ----
// Self-checking bench for the page-mode memory controller.
// Assumes the memory model and checker files are compiled first.
`timescale 1ns/100ps
module test_pmd_ctrl;
  import pmd_pkg::*;
  logic sys_clk, rst_n, req_valid, req_write, rd_ready, slow;
  logic req_ready, rd_valid, init_done, ras_n, cas_n, we_n, oe_n;
  logic data_line_oe, drv, ras_q = 1'b1, early = 1'b0;
  logic [3:0] req_wdata, rd_data, data_line_o, mem_q, dq;
  pmd_addr_t req_addr;
  pmd_maddr_t mux_address;
  logic [3:0] got [$];
  int mismatches = 0, check_count = 0, cycles = 0, cbr = 0, clash = 0;
  // The wire carries the controller's drive when enabled, otherwise the memory model's output.
  assign dq = data_line_oe ? data_line_o : mem_q;
  pmd_ctrl #(.INIT_CYC(20), .REF_CYC(300), .RAS_MAX_CYC(100)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .init_done(init_done), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .mux_address(mux_address),
    .data_line_i(dq), .data_line_o(data_line_o),
    .data_line_oe(data_line_oe));
  pmd_mem mem_model (
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .slow(slow),
    .mux_address(mux_address), .data_line_o(data_line_o),
    .data_line(mem_q), .drv(drv));
  // Clock of 4 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Collects read words, counts refreshes and clashes, cuts hangs.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    ras_q <= ras_n;
    if (rd_valid === 1'b1 && rd_ready === 1'b1) got.push_back(rd_data);
    if (ras_q && !ras_n && !cas_n) cbr <= cbr + 1;
    if (data_line_oe && drv) clash <= clash + 1;
    if (req_ready === 1'b1 && init_done !== 1'b1) early <= 1'b1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end
  task automatic check_word(input logic [3:0] exp, input logic [3:0] act);
    check_count++;
    if (act !== exp) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  task automatic check_num(input logic [17:0] exp, input logic [17:0] act);
    check_count++;
    if (act !== exp) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  // Holds one request until taken; may free the reader on cycle free_at.
  task automatic access(input logic wr, input pmd_addr_t a,
    input logic [3:0] d, input int free_at, output int n);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (n == free_at) rd_ready <= 1'b1;
    end while (req_ready !== 1'b1 && n < 3000);
    req_valid <= 1'b0;
    if (n >= 3000) mismatches++;
  endtask
  task automatic wait_words(input int k);
    int n;
    n = 0;
    while (got.size() < k && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // Writes four words at base plus a stride, then reads them back.
  task automatic rw_run(input pmd_addr_t base, input pmd_addr_t step);
    int n;
    got.delete();
    for (int i = 0; i < 4; i++)
      access(1'b1, pmd_addr_t'(base + step * i), 4'(i * 5 + 3), 0, n);
    for (int i = 0; i < 4; i++)
      access(1'b0, pmd_addr_t'(base + step * i), 4'h0, 0, n);
    wait_words(4);
    for (int i = 0; i < 4; i++) check_word(4'(i * 5 + 3), got[i]);
  endtask
  task automatic t_init;
    int n;
    access(1'b1, 18'h00000, 4'hA, 0, n);
    check_num(18'h00001, {17'h0, init_done});
    check_num(18'h00000, {17'h0, early});
    check_num(18'h00001, {17'h0, cbr >= 8});
    $display("test init finished");
  endtask
  task automatic t_rw;
    rw_run(18'h001FF, 18'h0FE00);
    check_num(18'h00000, 18'(clash));
    $display("test row change finished");
  endtask
  task automatic t_page;
    rw_run(18'h2A000, 18'h00001);
    $display("test page finished");
  endtask
  task automatic t_slow;
    slow <= 1'b1;
    rw_run(18'h155F8, 18'h00002);
    slow <= 1'b0;
    $display("test slow memory finished");
  endtask
  // Reader stalls: two reads fill the buffer, the third is held off.
  task automatic t_stall;
    int n;
    got.delete();
    rd_ready <= 1'b0;
    access(1'b0, 18'h2A000, 4'h0, 0, n);
    access(1'b0, 18'h2A001, 4'h0, 0, n);
    access(1'b0, 18'h2A002, 4'h0, 100, n);
    check_num(18'h00001, {17'h0, n > 100});
    wait_words(3);
    check_word(4'h3, got[0]);
    check_word(4'h8, got[1]);
    check_word(4'hD, got[2]);
    $display("test reader stall finished");
  endtask
  // Idle long enough for two refresh periods.
  task automatic t_refresh;
    int c0;
    logic [8:0] r0;
    c0 = cbr;
    r0 = mem_model.ref_ctr;
    repeat (800) @(posedge sys_clk);
    check_num(18'h00001, {17'h0, cbr - c0 >= 2});
    check_num(18'(cbr - c0), {9'h0, mem_model.ref_ctr - r0});
    $display("test refresh finished");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 18'h00000;
    req_wdata = 4'h0;
    rd_ready = 1'b1;
    slow = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_init;
    t_rw;
    t_page;
    t_slow;
    t_stall;
    t_refresh;
    give_verdict;
  end
endmodule
